// ==== src/ars_pkg.sv ====
package ars_pkg;

	localparam int ARS_GP_COUNT = 8;
	localparam logic [7:0] ARS_OFS_GP0 = 8'h00;
	localparam logic [7:0] ARS_OFS_PC = 8'h20;
	localparam logic [7:0] ARS_OFS_SP0 = 8'h24;
	localparam logic [7:0] ARS_OFS_SP1 = 8'h28;
	localparam logic [7:0] ARS_OFS_FP = 8'h2C;
	localparam logic [7:0] ARS_OFS_SB = 8'h30;
	localparam logic [7:0] ARS_OFS_DTB = 8'h34;
	localparam logic [7:0] ARS_OFS_UDP = 8'h38;
	localparam logic [7:0] ARS_OFS_PSR = 8'h3C;

	localparam int ARS_PSR_C = 0;
	localparam int ARS_PSR_T = 1;
	localparam int ARS_PSR_L = 2;
	localparam int ARS_PSR_V = 4;
	localparam int ARS_PSR_F = 5;
	localparam int ARS_PSR_Z = 6;
	localparam int ARS_PSR_N = 7;
	localparam int ARS_PSR_U = 8;
	localparam int ARS_PSR_S = 9;
	localparam int ARS_PSR_P = 10;
	localparam int ARS_PSR_I = 11;

	localparam logic [31:0] ARS_RST_WORD = 32'h0000_0000;
	localparam logic [15:0] ARS_RST_HALF = 16'h0000;
	localparam logic [31:0] ARS_LEN_BYTE = 32'h0000_0001;
	localparam logic [31:0] ARS_LEN_WORD = 32'h0000_0002;
	localparam logic [31:0] ARS_LEN_DWORD = 32'h0000_0004;

	typedef enum logic [1:0] {
		ARS_SZ_BYTE,
		ARS_SZ_WORD,
		ARS_SZ_DWORD
	} ars_size_type;

	typedef enum logic [2:0] {
		ARS_SPR_SP,
		ARS_SPR_USP,
		ARS_SPR_FP,
		ARS_SPR_SB,
		ARS_SPR_DTB,
		ARS_SPR_UDP,
		ARS_SPR_PSR,
		ARS_SPR_PSR_LO
	} ars_spr_type;

	function automatic logic [31:0] ars_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input ars_size_type sz);
		case (sz)
		ARS_SZ_BYTE: ars_merge = {old_v[31:8], new_v[7:0]};
		ARS_SZ_WORD: ars_merge = {old_v[31:16], new_v[15:0]};
		default: ars_merge = new_v;
		endcase
	endfunction

	function automatic logic [31:0] ars_low(input logic [31:0] v,
		input ars_size_type sz);
		ars_low = ars_merge(ARS_RST_WORD, v, sz);
	endfunction

	function automatic logic [31:0] ars_len(input ars_size_type sz);
		case (sz)
		ARS_SZ_BYTE: ars_len = ARS_LEN_BYTE;
		ARS_SZ_WORD: ars_len = ARS_LEN_WORD;
		default: ars_len = ARS_LEN_DWORD;
		endcase
	endfunction

	function automatic logic ars_spr_priv(input ars_spr_type sel);
		ars_spr_priv = (sel == ARS_SPR_USP) || (sel == ARS_SPR_DTB) ||
			(sel == ARS_SPR_PSR);
	endfunction

endpackage

// ==== src/ars_register_set.sv ====
`timescale 1ns/1ps
`default_nettype none
module ars_register_set
	import ars_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [2:0] gp_rd_sel,
	input wire ars_size_type gp_rd_size,
	output logic [31:0] gp_rd_data,
	input wire logic gp_wr_en,
	input wire logic [2:0] gp_wr_sel,
	input wire ars_size_type gp_wr_size,
	input wire logic [31:0] gp_wr_data,
	input wire logic pc_wr_en,
	input wire logic [31:0] pc_wr_data,
	output logic [31:0] pc_value,
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire ars_size_type stk_size,
	output logic [31:0] stk_addr,
	input wire logic spr_wr_en,
	input wire logic spr_rd_en,
	input wire ars_spr_type spr_sel,
	input wire logic [31:0] spr_wr_data,
	output logic [31:0] spr_rd_data,
	input wire logic priv_instr,
	output logic priv_violation,
	input wire logic alu_valid,
	input wire logic alu_carry,
	input wire logic alu_overflow,
	output logic overflow_trap,
	input wire logic cmp_valid,
	input wire logic cmp_float,
	input wire logic cmp_fp_equal,
	input wire logic cmp_fp_less,
	input wire logic [31:0] cmp_first,
	input wire logic [31:0] cmp_second,
	input wire logic instr_start,
	input wire logic instr_done,
	output logic trace_trap,
	input wire logic exc_take,
	input wire logic irq_req,
	input wire logic nmi_req,
	output logic irq_accept,
	output logic [15:0] psr_value
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] gp_reg [ARS_GP_COUNT];
	logic [31:0] gp_next [ARS_GP_COUNT];
	logic [31:0] pc_reg, sp0_reg, sp1_reg, fp_reg, sb_reg, dtb_reg;
	logic [31:0] pc_next, sp0_next, sp1_next, fp_next, sb_next, dtb_next;
	logic [15:0] udp_reg, udp_next, psr_reg, psr_next;
	logic [31:0] stk_addr_reg, stk_addr_next;
	logic [31:0] spr_rd_reg, spr_rd_next, gp_rd_reg, hrdata_reg;
	logic [31:0] bus_rd_word;
	logic priv_reg, priv_next, trace_reg, trace_next;
	logic ovf_reg, ovf_next, irq_reg, irq_next;
	logic bus_wr_reg;
	logic [7:0] bus_addr_reg;

	// ----------------------------------------------------------------
	// bus slave decode
	// ----------------------------------------------------------------
	// zero wait state; a read samples in the address phase, so a read
	// right behind a write to the same word sees the older value
	wire bus_take = hsel && hready && htrans[1];
	wire bus_rd = bus_take && !hwrite;
	wire bus_gp_wr = bus_wr_reg && (bus_addr_reg[7:5] == 3'h0);
	wire [2:0] bus_gp_idx = bus_addr_reg[4:2];
	wire bus_pc_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_PC);
	wire bus_sp0_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_SP0);
	wire bus_sp1_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_SP1);
	wire bus_fp_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_FP);
	wire bus_sb_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_SB);
	wire bus_dtb_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_DTB);
	wire bus_udp_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_UDP);
	wire bus_psr_wr = bus_wr_reg && (bus_addr_reg == ARS_OFS_PSR);

	always_comb begin
		case (haddr[7:0])
		ARS_OFS_PC: bus_rd_word = pc_reg;
		ARS_OFS_SP0: bus_rd_word = sp0_reg;
		ARS_OFS_SP1: bus_rd_word = sp1_reg;
		ARS_OFS_FP: bus_rd_word = fp_reg;
		ARS_OFS_SB: bus_rd_word = sb_reg;
		ARS_OFS_DTB: bus_rd_word = dtb_reg;
		ARS_OFS_UDP: bus_rd_word = {16'h0000, udp_reg};
		ARS_OFS_PSR: bus_rd_word = {16'h0000, psr_reg};
		default: begin
			if (haddr[7:5] == 3'h0 && haddr[1:0] == 2'h0) begin
				bus_rd_word = gp_reg[haddr[4:2]];
			end else begin
				bus_rd_word = ARS_RST_WORD;
			end
		end
		endcase
	end

	// ----------------------------------------------------------------
	// mode and stack selection
	// ----------------------------------------------------------------
	wire user_mode = psr_reg[ARS_PSR_U];
	wire use_sp1 = psr_reg[ARS_PSR_S];
	wire [31:0] sp_active = use_sp1 ? sp1_reg : sp0_reg;
	wire stk_op = stk_push || stk_pop;
	wire [31:0] stk_len = ars_len(stk_size);
	// push wins when both are raised together
	wire [31:0] sp_dec = sp_active - stk_len;
	wire [31:0] sp_inc = sp_active + stk_len;
	wire [31:0] sp_new = stk_push ? sp_dec : sp_inc;
	wire spr_touch = spr_wr_en || spr_rd_en;
	wire spr_denied = user_mode && ars_spr_priv(spr_sel);
	wire spr_wr_ok = spr_wr_en && !spr_denied;
	wire sp_wr = spr_wr_ok && (spr_sel == ARS_SPR_SP);
	// user stack alias bypasses the select flag
	wire usp_wr = spr_wr_ok && (spr_sel == ARS_SPR_USP);

	assign stk_addr_next = stk_push ? sp_dec : (stk_pop ? sp_active :
		stk_addr_reg);

	// the stack engine outranks special loads, which outrank the bus
	assign sp0_next = (stk_op && !use_sp1) ? sp_new :
		(sp_wr && !use_sp1) ? spr_wr_data :
		bus_sp0_wr ? hwdata : sp0_reg;
	assign sp1_next = (stk_op && use_sp1) ? sp_new :
		((sp_wr && use_sp1) || usp_wr) ? spr_wr_data :
		bus_sp1_wr ? hwdata : sp1_reg;
	assign fp_next = (spr_wr_ok && spr_sel == ARS_SPR_FP) ? spr_wr_data :
		bus_fp_wr ? hwdata : fp_reg;
	assign sb_next = (spr_wr_ok && spr_sel == ARS_SPR_SB) ? spr_wr_data :
		bus_sb_wr ? hwdata : sb_reg;
	assign dtb_next = (spr_wr_ok && spr_sel == ARS_SPR_DTB) ?
		spr_wr_data : bus_dtb_wr ? hwdata : dtb_reg;
	// only 16 bits kept, so descriptors sit in the lowest 64 kbytes
	assign udp_next = (spr_wr_ok && spr_sel == ARS_SPR_UDP) ?
		spr_wr_data[15:0] : bus_udp_wr ? hwdata[15:0] :
		udp_reg;
	assign pc_next = pc_wr_en ? pc_wr_data :
		bus_pc_wr ? hwdata : pc_reg;

	always_comb begin
		case (spr_sel)
		ARS_SPR_SP: spr_rd_next = sp_active;
		ARS_SPR_USP: spr_rd_next = sp1_reg;
		ARS_SPR_FP: spr_rd_next = fp_reg;
		ARS_SPR_SB: spr_rd_next = sb_reg;
		ARS_SPR_DTB: spr_rd_next = dtb_reg;
		ARS_SPR_UDP: spr_rd_next = {16'h0000, udp_reg};
		ARS_SPR_PSR: spr_rd_next = {16'h0000, psr_reg};
		default: spr_rd_next = {24'h000000, psr_reg[7:0]};
		endcase
		if (!spr_rd_en || spr_denied) begin
			spr_rd_next = ARS_RST_WORD;
		end
	end

	// ----------------------------------------------------------------
	// general registers
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < ARS_GP_COUNT; i++) begin
			gp_next[i] = gp_reg[i];
			if (bus_gp_wr && bus_gp_idx == 3'(i)) begin
				gp_next[i] = hwdata;
			end
			if (gp_wr_en && gp_wr_sel == 3'(i)) begin
				gp_next[i] = ars_merge(gp_reg[i], gp_wr_data,
					gp_wr_size);
			end
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	wire cmp_lt_u = cmp_second < cmp_first;
	wire cmp_lt_s = $signed(cmp_second) < $signed(cmp_first);
	wire cmp_eq = cmp_second == cmp_first;
	wire psr_spr_full = spr_wr_en && spr_sel == ARS_SPR_PSR;
	wire psr_spr_low = spr_wr_en && spr_sel == ARS_SPR_PSR_LO;

	always_comb begin
		psr_next = psr_reg;
		if (bus_psr_wr) begin
			psr_next = hwdata[15:0];
		end
		// a user write keeps its low byte, the high byte is dropped
		if (psr_spr_full && !user_mode) begin
			psr_next = spr_wr_data[15:0];
		end else if (psr_spr_full || psr_spr_low) begin
			psr_next[7:0] = spr_wr_data[7:0];
		end
		if (alu_valid) begin
			psr_next[ARS_PSR_C] = alu_carry;
			psr_next[ARS_PSR_F] = alu_overflow;
		end
		if (cmp_valid) begin
			psr_next[ARS_PSR_L] = !cmp_float && cmp_lt_u;
			psr_next[ARS_PSR_Z] = cmp_float ? cmp_fp_equal :
				cmp_eq;
			psr_next[ARS_PSR_N] = cmp_float ? cmp_fp_less :
				cmp_lt_s;
		end
		if (instr_done && psr_reg[ARS_PSR_P]) begin
			psr_next[ARS_PSR_P] = 1'b0;
		end
		if (instr_start && psr_reg[ARS_PSR_T]) begin
			psr_next[ARS_PSR_P] = 1'b1;
		end
		if (exc_take) begin
			psr_next[ARS_PSR_S] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// events to exception logic
	// ----------------------------------------------------------------
	// pending bit, not the trace flag, fires the trap: one per instruction
	assign trace_next = instr_done && psr_reg[ARS_PSR_P];
	assign ovf_next = alu_valid && alu_overflow &&
		psr_reg[ARS_PSR_V];
	assign irq_next = nmi_req || (irq_req &&
		psr_reg[ARS_PSR_I]);
	assign priv_next = user_mode && (priv_instr ||
		(spr_touch && ars_spr_priv(spr_sel)));

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < ARS_GP_COUNT; i++) begin
				gp_reg[i] <= ARS_RST_WORD;
			end
		end else begin
			for (int i = 0; i < ARS_GP_COUNT; i++) begin
				gp_reg[i] <= gp_next[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_reg <= ARS_RST_WORD;
			sp0_reg <= ARS_RST_WORD;
			sp1_reg <= ARS_RST_WORD;
			fp_reg <= ARS_RST_WORD;
			sb_reg <= ARS_RST_WORD;
			dtb_reg <= ARS_RST_WORD;
			udp_reg <= ARS_RST_HALF;
			psr_reg <= ARS_RST_HALF;
		end else begin
			pc_reg <= pc_next;
			sp0_reg <= sp0_next;
			sp1_reg <= sp1_next;
			fp_reg <= fp_next;
			sb_reg <= sb_next;
			dtb_reg <= dtb_next;
			udp_reg <= udp_next;
			psr_reg <= psr_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stk_addr_reg <= ARS_RST_WORD;
			spr_rd_reg <= ARS_RST_WORD;
			gp_rd_reg <= ARS_RST_WORD;
			priv_reg <= 1'b0;
			trace_reg <= 1'b0;
			ovf_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			stk_addr_reg <= stk_addr_next;
			spr_rd_reg <= spr_rd_next;
			gp_rd_reg <= ars_low(gp_reg[gp_rd_sel],
				gp_rd_size);
			priv_reg <= priv_next;
			trace_reg <= trace_next;
			ovf_reg <= ovf_next;
			irq_reg <= irq_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_wr_reg <= 1'b0;
			bus_addr_reg <= 8'h00;
			hrdata_reg <= ARS_RST_WORD;
		end else begin
			if (hready) begin
				bus_wr_reg <= bus_take && hwrite;
				bus_addr_reg <= haddr[7:0];
			end
			if (bus_rd) begin
				hrdata_reg <= bus_rd_word;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign gp_rd_data = gp_rd_reg;
	assign pc_value = pc_reg;
	assign stk_addr = stk_addr_reg;
	assign spr_rd_data = spr_rd_reg;
	assign priv_violation = priv_reg;
	assign overflow_trap = ovf_reg;
	assign trace_trap = trace_reg;
	assign irq_accept = irq_reg;
	assign psr_value = psr_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence seq_trace_arm;
		instr_start && psr_reg[ARS_PSR_T] && !instr_done;
	endsequence
	sequence seq_trace_end;
		instr_done && !instr_start && !exc_take;
	endsequence

	chk_trace_after_done: assert property (
		seq_trace_arm ##1 seq_trace_end |=> trace_trap)
		else $error("trace trap missing after traced instruction");
	chk_trace_once: assert property (
		trace_trap && !$past(instr_start) |-> !psr_reg[ARS_PSR_P])
		else $error("trace pending left set after trace trap");
	chk_psr_high_guard: assert property (
		user_mode && !bus_psr_wr |=> psr_reg[ARS_PSR_U] &&
		psr_reg[ARS_PSR_I] == $past(psr_reg[ARS_PSR_I]))
		else $error("user mode changed supervisor flags");
	chk_priv_report: assert property (
		user_mode && priv_instr |=> priv_violation)
		else $error("privilege violation not reported");
	chk_select_clear: assert property (
		exc_take |=> !psr_reg[ARS_PSR_S])
		else $error("stack select not cleared on exception");
	chk_push_addr: assert property (
		stk_push && !sp_wr && !usp_wr && !exc_take |=>
		stk_addr == $past(sp_active) - $past(stk_len) &&
		sp_active == stk_addr)
		else $error("push did not predecrement stack pointer");
	chk_pop_addr: assert property (
		stk_pop && !stk_push && !exc_take |=>
		stk_addr == $past(sp_active) &&
		sp_active == $past(sp_active) + $past(stk_len))
		else $error("pop did not postincrement stack pointer");
	chk_zero_flag: assert property (
		cmp_valid && !cmp_float |=>
		psr_reg[ARS_PSR_Z] == ($past(cmp_first) == $past(cmp_second)))
		else $error("zero flag wrong after compare");
	chk_ovf_trap: assert property (
		ovf_reg |-> $past(alu_overflow && alu_valid &&
		psr_reg[ARS_PSR_V]))
		else $error("overflow trap without enabled overflow");
	chk_irq_mask: assert property (
		irq_req && !nmi_req && !psr_reg[ARS_PSR_I] |=> !irq_accept)
		else $error("masked interrupt accepted");
	chk_gp_narrow: assert property (
		gp_wr_en && gp_wr_size == ARS_SZ_BYTE && !bus_gp_wr |=>
		gp_reg[$past(gp_wr_sel)][31:8] ==
		$past(gp_reg[gp_wr_sel][31:8]))
		else $error("byte write disturbed upper bits");

endmodule
`default_nettype wire

// ==== tb/ars_exec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// execution unit standing in for the core
// ----------------------------------------
module ars_exec_model (
	input wire logic hclk,
	input wire logic go,
	input wire logic [1:0] op,
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	output var logic alu_valid,
	output var logic alu_carry,
	output var logic alu_overflow,
	output var logic cmp_valid,
	output var logic cmp_float,
	output var logic cmp_fp_equal,
	output var logic cmp_fp_less,
	output var logic [31:0] cmp_first,
	output var logic [31:0] cmp_second
);
	logic [32:0] sum;
	logic sub;
	// op: 0 add, 1 subtract, 2 integer compare, 3 float compare
	assign sub = op[0];
	assign sum = sub ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
	always_comb begin
		alu_valid = go && !op[1];
		cmp_valid = go && op[1];
		alu_carry = sum[32];
		alu_overflow = (sub ? a[31] != b[31] : a[31] == b[31]) &&
			(sum[31] != a[31]);
		cmp_float = op[0];
		cmp_fp_equal = a == b;
		cmp_fp_less = $signed(b) < $signed(a);
		// operands are only meaningful while go is high
		cmp_first = go ? a : ~a;
		cmp_second = go ? b : ~b;
	end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ars_pkg::*;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = '0, hwdata = '0, gp_wr_data = '0, pc_wr_data = '0;
	logic [31:0] spr_wr_data = '0, a = '0, b = '0, hrdata, pc_value;
	logic [31:0] gp_rd_data, spr_rd_data, cmp_first, cmp_second, stk_addr;
	logic [2:0] hsize = 3'h2, gp_rd_sel = 3'h0, gp_wr_sel = 3'h0;
	logic [1:0] htrans = 2'h0, op = 2'h0;
	logic [15:0] psr_value;
	logic gp_wr_en = 1'h0, pc_wr_en = 1'h0, stk_push = 1'h0, stk_pop = 1'h0;
	logic spr_wr_en = 1'h0, spr_rd_en = 1'h0, priv_instr = 1'h0, go = 1'h0;
	logic instr_start = 1'h0, instr_done = 1'h0, exc_take = 1'h0;
	logic irq_req = 1'h0, nmi_req = 1'h0;
	logic hready, hreadyout, hresp, priv_violation, alu_valid, alu_carry;
	logic alu_overflow, overflow_trap, cmp_valid, cmp_float, cmp_fp_equal;
	logic cmp_fp_less, trace_trap, irq_accept;
	ars_size_type gp_rd_size = ARS_SZ_DWORD, gp_wr_size = ARS_SZ_DWORD;
	ars_size_type stk_size = ARS_SZ_DWORD;
	ars_spr_type spr_sel = ARS_SPR_SP;
	int num_errors = 0, total_checks = 0, seed = 41866;
	logic [31:0] v, e, sp, r;

	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;
	ars_register_set uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.gp_rd_sel(gp_rd_sel), .gp_rd_size(gp_rd_size),
		.gp_rd_data(gp_rd_data), .gp_wr_en(gp_wr_en),
		.gp_wr_sel(gp_wr_sel), .gp_wr_size(gp_wr_size),
		.gp_wr_data(gp_wr_data), .pc_wr_en(pc_wr_en),
		.pc_wr_data(pc_wr_data), .pc_value(pc_value),
		.stk_push(stk_push), .stk_pop(stk_pop),
		.stk_size(stk_size), .stk_addr(stk_addr),
		.spr_wr_en(spr_wr_en), .spr_rd_en(spr_rd_en),
		.spr_sel(spr_sel), .spr_wr_data(spr_wr_data),
		.spr_rd_data(spr_rd_data), .priv_instr(priv_instr),
		.priv_violation(priv_violation), .alu_valid(alu_valid),
		.alu_carry(alu_carry), .alu_overflow(alu_overflow),
		.overflow_trap(overflow_trap), .cmp_valid(cmp_valid),
		.cmp_float(cmp_float), .cmp_fp_equal(cmp_fp_equal),
		.cmp_fp_less(cmp_fp_less), .cmp_first(cmp_first),
		.cmp_second(cmp_second), .instr_start(instr_start),
		.instr_done(instr_done), .trace_trap(trace_trap),
		.exc_take(exc_take), .irq_req(irq_req),
		.nmi_req(nmi_req), .irq_accept(irq_accept),
		.psr_value(psr_value)
	);
	ars_exec_model model (
		.hclk(hclk), .go(go), .op(op), .a(a), .b(b),
		.alu_valid(alu_valid), .alu_carry(alu_carry),
		.alu_overflow(alu_overflow), .cmp_valid(cmp_valid),
		.cmp_float(cmp_float), .cmp_fp_equal(cmp_fp_equal),
		.cmp_fp_less(cmp_fp_less), .cmp_first(cmp_first),
		.cmp_second(cmp_second)
	);

	// ----------------------------------------
	// checking and bus helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 50);
		q = hrdata;
		hsel <= 1'h0;
		if (n >= 50) num_errors++;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, ad, d, q);
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
		logic [31:0] q;
		bus(1'h0, ad, 32'h0, q);
		chk(q, x);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// ----------------------------------------
	// execution side stimulus
	// ----------------------------------------
	task automatic exe(input logic [1:0] o, input logic [31:0] x,
		input logic [31:0] y);
		@(posedge hclk);
		op <= o;
		a <= x;
		b <= y;
		go <= 1'h1;
		@(posedge hclk);
		go <= 1'h0;
		#1;
	endtask

	task automatic stk(input logic push, input int k, input logic [31:0] x);
		@(posedge hclk);
		stk_push <= push;
		stk_pop <= !push;
		stk_size <= ars_size_type'(k);
		@(posedge hclk);
		stk_push <= 1'h0;
		stk_pop <= 1'h0;
		#1 chk(stk_addr, x);
	endtask

	task automatic spr(input logic w, input ars_spr_type s,
		input logic [31:0] d);
		@(posedge hclk);
		spr_wr_en <= w;
		spr_rd_en <= !w;
		spr_sel <= s;
		spr_wr_data <= d;
		@(posedge hclk);
		spr_wr_en <= 1'h0;
		spr_rd_en <= 1'h0;
		#1;
	endtask

	function automatic logic [31:0] keep(input logic [31:0] o,
		input logic [31:0] n, input int bits);
		logic [31:0] m;
		m = (bits == 32) ? 32'hFFFF_FFFF : (32'h1 << bits) - 32'h1;
		keep = (o & ~m) | (n & m);
	endfunction

	function automatic logic [31:0] cmpx(input logic [31:0] f,
		input logic [31:0] s, input logic fl);
		cmpx = {24'h0, $signed(s) < $signed(f), s == f, 3'h0,
			!fl && s < f, 2'h0};
	endfunction

	function automatic logic [31:0] arx(input logic [31:0] f,
		input logic [31:0] s, input logic sb);
		logic [32:0] t;
		logic c;
		t = sb ? {f[31], f} - {s[31], s} : {f[31], f} + {s[31], s};
		c = sb ? f < s : (f + s) < f;
		arx = {26'h0, t[32] != t[31], 4'h0, c};
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		rdc(ARS_OFS_PSR, 32'h0);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			wr(8'(i * 4), v);
			rdc(8'(i * 4), v);
		end
		wr(ARS_OFS_UDP, 32'hFFFF_FFFF);
		rdc(ARS_OFS_UDP, 32'h0000_FFFF);
		rdc(8'h40, 32'h0);
		for (int k = 0; k < 3; k++) begin
			v = $random(seed);
			e = $random(seed);
			wr(8'h0C, v);
			@(posedge hclk);
			gp_wr_en <= 1'h1;
			gp_wr_sel <= 3'h3;
			gp_wr_size <= ars_size_type'(k);
			gp_wr_data <= e;
			gp_rd_sel <= 3'h3;
			gp_rd_size <= ars_size_type'(k);
			@(posedge hclk);
			gp_wr_en <= 1'h0;
			@(posedge hclk);
			#1 chk(gp_rd_data, keep(32'h0, e, 8 << k));
			rdc(8'h0C, keep(v, e, 8 << k));
		end
		v = $random(seed);
		@(posedge hclk);
		pc_wr_en <= 1'h1;
		pc_wr_data <= v;
		@(posedge hclk);
		pc_wr_en <= 1'h0;
		#1 chk(pc_value, v);
		rdc(ARS_OFS_PC, v);
		sp = $random(seed);
		wr(ARS_OFS_SP0, sp);
		wr(ARS_OFS_SP1, ~sp);
		for (int k = 0; k < 3; k++) begin
			sp = sp - (32'h1 << k);
			stk(1'h1, k, sp);
		end
		for (int k = 0; k < 3; k++) begin
			stk(1'h0, k, sp);
			sp = sp + (32'h1 << k);
		end
		rdc(ARS_OFS_SP0, sp);
		wr(ARS_OFS_PSR, 32'h0000_0200);
		stk(1'h1, 2, ~sp - 32'h4);
		@(posedge hclk);
		exc_take <= 1'h1;
		@(posedge hclk);
		exc_take <= 1'h0;
		#1 chk({16'h0, psr_value & 16'h0200}, 32'h0);
		spr(1'h0, ARS_SPR_USP, 32'h0);
		chk(spr_rd_data, ~sp - 32'h4);
		// user mode: privileged writes are dropped, low byte still lands
		wr(ARS_OFS_PSR, 32'h0000_0100);
		spr(1'h1, ARS_SPR_PSR, 32'h0000_00F5);
		chk({31'h0, priv_violation}, 32'h1);
		chk({16'h0, psr_value}, 32'h0000_01F5);
		spr(1'h1, ARS_SPR_USP, 32'h0);
		chk({31'h0, priv_violation}, 32'h1);
		rdc(ARS_OFS_SP1, ~sp - 32'h4);
		for (int u = 0; u < 2; u++) begin
			wr(ARS_OFS_PSR, 32'(u) << 8);
			@(posedge hclk);
			priv_instr <= 1'h1;
			@(posedge hclk);
			priv_instr <= 1'h0;
			#1 chk({31'h0, priv_violation}, 32'(u));
		end
		wr(ARS_OFS_PSR, 32'h0);
		for (int i = 0; i < 24; i++) begin
			v = $random(seed);
			e = (i % 4 == 0) ? v : $random(seed);
			if (i % 4 == 1) e = v ^ 32'h8000_0000;
			exe(2'h2 | 2'(i % 2), v, e);
			r = cmpx(v, e, i[0]);
			chk({16'h0, psr_value & 16'h00C4}, r);
		end
		for (int i = 0; i < 24; i++) begin
			v = $random(seed);
			e = $random(seed);
			if (i < 4) v = 32'h7FFF_FFFF;
			if (i < 4) e = 32'h1;
			wr(ARS_OFS_PSR, {27'h0, i[1], 4'h0});
			exe(2'(i % 2), v, e);
			r = arx(v, e, i[0]);
			chk({16'h0, psr_value & 16'h0021}, r);
			chk({31'h0, overflow_trap}, {31'h0, i[1] & r[5]});
		end
		wr(ARS_OFS_PSR, 32'h0000_0002);
		@(posedge hclk);
		instr_start <= 1'h1;
		@(posedge hclk);
		instr_start <= 1'h0;
		#1 chk({16'h0, psr_value & 16'h0400}, 32'h400);
		for (int k = 0; k < 2; k++) begin
			@(posedge hclk);
			instr_done <= 1'h1;
			@(posedge hclk);
			instr_done <= 1'h0;
			#1 chk({31'h0, trace_trap}, 32'(k == 0));
		end
		chk({16'h0, psr_value & 16'h0400}, 32'h0);
		// done right behind start: the trap must still come exactly once
		@(posedge hclk);
		instr_start <= 1'h1;
		@(posedge hclk);
		instr_start <= 1'h0;
		instr_done <= 1'h1;
		@(posedge hclk);
		instr_done <= 1'h0;
		#1 chk({31'h0, trace_trap}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wr(ARS_OFS_PSR, {20'h0, i[2], 11'h0});
			irq_req <= i[0];
			nmi_req <= i[1];
			repeat (2) @(posedge hclk);
			e = {31'h0, i[1] | (i[0] & i[2])};
			#1 chk({31'h0, irq_accept}, e);
		end
		results();
	end

	// the sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		#100000;
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
